// [pwr_ctrl_pkg.sv]
// package: register map, field layout and timing constants of the power control block
package pwr_ctrl_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] power_control_status_off = 12'h084;

    // ****************************************
    // field positions
    // ****************************************
    localparam int sleep_state_select_hi  = 31;
    localparam int sleep_state_select_lo  = 29;
    localparam int sleep_entry_trigger_b  = 28;
    localparam int auto_wake_enable_b     = 27;
    localparam int indicator_outputs_off_b = 26;
    localparam int core_clock_gate_b      = 21;
    localparam int port_b_flag_b          = 17;
    localparam int port_a_flag_b          = 16;
    localparam int port_b_enable_b        = 15;
    localparam int port_a_enable_b        = 14;
    localparam int pin_select_hi          = 9;
    localparam int pin_select_lo          = 7;
    localparam int buffer_type_b          = 6;
    localparam int pulse_mode_b           = 3;
    localparam int polarity_b             = 2;
    localparam int wake_enable_b          = 1;
    localparam int ready_b                = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [2:0] sleep_state_reset = 3'h0;
    localparam logic [2:0] pin_select_reset  = 3'h0;

    // ****************************************
    // encodings
    // ****************************************
    localparam logic [2:0] run_state     = 3'h0;
    localparam logic [2:0] light_sleep   = 3'h1;
    localparam logic [2:0] deeper_sleep  = 3'h2;
    localparam logic [2:0] deepest_sleep = 3'h3;

    localparam logic [2:0] pin_none        = 3'h0;
    localparam logic [2:0] pin_error_led   = 3'h1;
    localparam logic [2:0] pin_wait_ack    = 3'h2;
    localparam logic [2:0] pin_sync_latch0 = 3'h3;
    localparam logic [2:0] pin_sync_latch1 = 3'h4;

    // ****************************************
    // timing
    // ****************************************
    localparam longint clk_freq_hz    = 250000000;
    localparam longint wake_pulse_ms  = 50;
    localparam longint wake_pulse_cyc = (wake_pulse_ms * clk_freq_hz) / 1000;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic error_indicator_pin;
        logic wait_ack_pin;
        logic sync_latch_0_pin;
        logic sync_latch_1_pin;
    } wake_pins_s;

endpackage

// [wake_pulse_timer.sv]
// module: one-shot timer stretching a wake event into a fixed-length pulse
`timescale 1ns/1ns
module wake_pulse_timer #(
    parameter longint PULSE_CYC = pwr_ctrl_pkg::wake_pulse_cyc
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic start_i,
    input  wire logic abort_i,
    output logic      busy_o
);

    localparam int CW = $clog2(PULSE_CYC + 1);

    logic [CW-1:0] count_q;

    // load on start, count down to zero, abort drops it at once
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= '0;
        end else if (abort_i) begin
            count_q <= '0;
        end else if (start_i) begin
            count_q <= CW'(PULSE_CYC);
        end else if (count_q != '0) begin
            count_q <= count_q - CW'(1);
        end
    end

    assign busy_o = (count_q != '0);

endmodule

// [power_mode_wake_ready_ctrl.sv]
// module: power control register, sleep sequencing, wake output and ready flag
//
// How it works
// - three-bit sleep state select in bits 31:29, top-bit codes reserved
// - select write dropped if trigger set; trigger set dropped if select changes
// - bit 28 set enters selected sleep state and reads one while sleeping
// - wake-up clears select field and trigger by hardware
// - bit 27 lets wake events end sleep except in the deepest state; otherwise host wake only
// - bit 26 releases open-drain indicators, holds push-pull ones inactive
// - bit 21 sets after two consecutive one writes; zero restarts count
// - bits 17,16 flag port events; write one clears once source gone
// - enables 15,14 route port events to top power event status
// - bits 9:7 route wake output to none or one of four pins
// - selected pin stays undriven unless wake output enable set
// - bit 6 clear gives open-drain active low, set gives push-pull
// - bit 2 sets push-pull wake output active high, else active low
// - bit 3 gives 50 ms pulse, else level until flags or enables clear
// - bit 1 gates external wake pin only, not the top status bit
// - pin select, buffer type, polarity survive digital reset
// - bit 0 read-only ready, mirrored out; rising edge pulses ready event
// - ready low in sleep, high again after run state and pll lock
// - ready rises after config load; core reset reloads and drops it
// - register readable any time, reads return the whole word whatever the byte enables
`timescale 1ns/1ns
module power_mode_wake_ready_ctrl #(
    parameter longint WAKE_PULSE_CYC = pwr_ctrl_pkg::wake_pulse_cyc
) (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_n_i,
    // avalon-mm slave
    input  wire logic [11:0]              avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output logic [31:0]                   avs_readdata,
    output logic                          avs_waitrequest,
    output logic [1:0]                    avs_response,
    // resets and configuration load
    input  wire logic                     digital_reset_i,
    input  wire logic                     core_reset_i,
    input  wire logic                     config_loaded_i,
    // sleep / wake
    input  wire logic                     pll_locked_i,
    input  wire logic                     host_wake_i,
    input  wire logic                     port_a_event_i,
    input  wire logic                     port_b_event_i,
    output logic                          sleep_active_o,
    output logic [2:0]                    sleep_state_o,
    // controls to the rest of the chip
    output logic                          fieldbus_core_clock_gate_o,
    output logic                          indicator_outputs_off_o,
    output logic                          power_event_irq_status_o,
    output logic                          ready_o,
    output logic                          ready_rise_o,
    // wake output pins, oe low means driving
    output pwr_ctrl_pkg::wake_pins_s      wake_pin_out_o,
    output pwr_ctrl_pkg::wake_pins_s      wake_pin_oe_n_o
);

    // ****************************************
    // register state
    // ****************************************
    logic [2:0] sleep_sel_q;
    logic       sleep_trig_q;
    logic       auto_wake_q;
    logic       led_off_q;
    logic       clk_gate_q;
    logic       gate_armed_q;
    logic       flag_a_q;
    logic       flag_b_q;
    logic       en_a_q;
    logic       en_b_q;
    logic [2:0] pin_sel_q;
    logic       buf_pp_q;
    logic       pulse_mode_q;
    logic       pol_high_q;
    logic       wake_en_q;
    logic       ready_q;
    logic       ready_prev_q;
    logic       wait_q;
    logic [31:0] rdata_q;
    logic [1:0]  resp_q;

    logic        hit;
    logic        wr_acc;
    logic        rd_acc;
    logic [31:0] wmask;
    logic [31:0] wdat;
    logic        be3_wr;
    logic        be2_wr;
    logic        be1_wr;
    logic        be0_wr;
    logic        wake_up;
    logic        sel_change;
    logic        trig_write;
    logic        trig_set;
    logic        event_any;
    logic        event_rise;
    logic        event_prev_q;
    logic        pulse_busy;
    logic        wake_active;
    logic        pin_level;
    logic        loading_q;

    // ****************************************
    // bus decode
    // ****************************************
    assign hit    = (avs_address == pwr_ctrl_pkg::power_control_status_off);
    assign wr_acc = avs_write && !avs_waitrequest;
    assign rd_acc = avs_read && !avs_waitrequest;
    assign be3_wr = wr_acc && hit && avs_byteenable[3];
    assign be2_wr = wr_acc && hit && avs_byteenable[2];
    assign be1_wr = wr_acc && hit && avs_byteenable[1];
    assign be0_wr = wr_acc && hit && avs_byteenable[0];
    assign wdat   = avs_writedata;
    assign wmask  = {{8{be3_wr}}, {8{be2_wr}}, {8{be1_wr}}, {8{be0_wr}}};

    // one wait state per access, so every request answers on its second edge
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 1'b1;
        end else if ((avs_read || avs_write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end
    assign avs_waitrequest = wait_q;

    // ****************************************
    // sleep select and trigger
    // ****************************************
    assign trig_write = be3_wr && wdat[pwr_ctrl_pkg::sleep_entry_trigger_b];
    assign sel_change = be3_wr && (wdat[pwr_ctrl_pkg::sleep_state_select_hi:
                                        pwr_ctrl_pkg::sleep_state_select_lo] != sleep_sel_q);
    assign trig_set   = trig_write && !sel_change;
    // wake from sleep: host access, or auto wake event when not in the deepest state
    assign wake_up    = sleep_trig_q && pll_locked_i &&
                        (host_wake_i ||
                         (auto_wake_q && event_any &&
                          sleep_sel_q != pwr_ctrl_pkg::deepest_sleep));

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sleep_sel_q  <= pwr_ctrl_pkg::sleep_state_reset;
            sleep_trig_q <= 1'b0;
        end else if (digital_reset_i || wake_up) begin
            sleep_sel_q  <= pwr_ctrl_pkg::sleep_state_reset;
            sleep_trig_q <= 1'b0;
        end else if (be3_wr && !sleep_trig_q) begin
            if (!trig_write) begin
                sleep_sel_q <= wdat[pwr_ctrl_pkg::sleep_state_select_hi:
                                    pwr_ctrl_pkg::sleep_state_select_lo];
            end
            if (trig_set) begin
                sleep_trig_q <= 1'b1;
            end
        end
    end

    assign sleep_active_o = sleep_trig_q;
    assign sleep_state_o  = sleep_trig_q ? sleep_sel_q : pwr_ctrl_pkg::run_state;

    // ****************************************
    // plain control bits
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            auto_wake_q  <= 1'b0;
            led_off_q    <= 1'b0;
            en_a_q       <= 1'b0;
            en_b_q       <= 1'b0;
            pulse_mode_q <= 1'b0;
            wake_en_q    <= 1'b0;
        end else if (digital_reset_i) begin
            auto_wake_q  <= 1'b0;
            led_off_q    <= 1'b0;
            en_a_q       <= 1'b0;
            en_b_q       <= 1'b0;
            pulse_mode_q <= 1'b0;
            wake_en_q    <= 1'b0;
        end else begin
            if (wmask[pwr_ctrl_pkg::auto_wake_enable_b])
                auto_wake_q <= wdat[pwr_ctrl_pkg::auto_wake_enable_b];
            if (wmask[pwr_ctrl_pkg::indicator_outputs_off_b])
                led_off_q <= wdat[pwr_ctrl_pkg::indicator_outputs_off_b];
            if (wmask[pwr_ctrl_pkg::port_a_enable_b])
                en_a_q <= wdat[pwr_ctrl_pkg::port_a_enable_b];
            if (wmask[pwr_ctrl_pkg::port_b_enable_b])
                en_b_q <= wdat[pwr_ctrl_pkg::port_b_enable_b];
            if (wmask[pwr_ctrl_pkg::pulse_mode_b])
                pulse_mode_q <= wdat[pwr_ctrl_pkg::pulse_mode_b];
            if (wmask[pwr_ctrl_pkg::wake_enable_b])
                wake_en_q <= wdat[pwr_ctrl_pkg::wake_enable_b];
        end
    end
    assign indicator_outputs_off_o = led_off_q;

    // wake pin configuration, untouched by digital reset
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_sel_q  <= pwr_ctrl_pkg::pin_select_reset;
            buf_pp_q   <= 1'b0;
            pol_high_q <= 1'b0;
        end else begin
            if (wmask[pwr_ctrl_pkg::pin_select_lo])
                pin_sel_q <= wdat[pwr_ctrl_pkg::pin_select_hi:pwr_ctrl_pkg::pin_select_lo];
            if (wmask[pwr_ctrl_pkg::buffer_type_b])
                buf_pp_q <= wdat[pwr_ctrl_pkg::buffer_type_b];
            if (wmask[pwr_ctrl_pkg::polarity_b])
                pol_high_q <= wdat[pwr_ctrl_pkg::polarity_b];
        end
    end

    // core clock gate: needs two one-writes in a row, a zero-write clears it
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_gate_q   <= 1'b0;
            gate_armed_q <= 1'b0;
        end else if (digital_reset_i) begin
            clk_gate_q   <= 1'b0;
            gate_armed_q <= 1'b0;
        end else if (wmask[pwr_ctrl_pkg::core_clock_gate_b]) begin
            if (wdat[pwr_ctrl_pkg::core_clock_gate_b]) begin
                gate_armed_q <= 1'b1;
                if (gate_armed_q)
                    clk_gate_q <= 1'b1;
            end else begin
                gate_armed_q <= 1'b0;
                clk_gate_q   <= 1'b0;
            end
        end
    end
    assign fieldbus_core_clock_gate_o = clk_gate_q;

    // ****************************************
    // port event flags
    // ****************************************
    // set wins over clear; a one-write clears only when the source is gone
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_a_q <= 1'b0;
            flag_b_q <= 1'b0;
        end else if (digital_reset_i) begin
            flag_a_q <= 1'b0;
            flag_b_q <= 1'b0;
        end else begin
            if (port_a_event_i)
                flag_a_q <= 1'b1;
            else if (wmask[pwr_ctrl_pkg::port_a_flag_b] && wdat[pwr_ctrl_pkg::port_a_flag_b])
                flag_a_q <= 1'b0;
            if (port_b_event_i)
                flag_b_q <= 1'b1;
            else if (wmask[pwr_ctrl_pkg::port_b_flag_b] && wdat[pwr_ctrl_pkg::port_b_flag_b])
                flag_b_q <= 1'b0;
        end
    end

    assign event_any = (flag_a_q && en_a_q) || (flag_b_q && en_b_q);
    assign power_event_irq_status_o = event_any;

    // ****************************************
    // wake output
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_prev_q <= 1'b0;
        end else begin
            event_prev_q <= event_any;
        end
    end
    assign event_rise = event_any && !event_prev_q;

    wake_pulse_timer #(
        .PULSE_CYC (WAKE_PULSE_CYC)
    ) u_pulse (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (event_rise && pulse_mode_q),
        .abort_i   (!event_any),
        .busy_o    (pulse_busy)
    );

    assign wake_active = pulse_mode_q ? pulse_busy : event_any;

    // open-drain: pull low when active, release otherwise; push-pull: polarity
    always_comb begin
        pwr_ctrl_pkg::wake_pins_s o;
        pwr_ctrl_pkg::wake_pins_s e;
        logic drive;
        o = '1;
        e = '1;
        pin_level = buf_pp_q ? (wake_active ~^ pol_high_q) : 1'b0;
        drive     = wake_en_q && (buf_pp_q || wake_active);
        unique case (pin_sel_q)
            pwr_ctrl_pkg::pin_error_led: begin
                o.error_indicator_pin = pin_level;
                e.error_indicator_pin = !drive;
            end
            pwr_ctrl_pkg::pin_wait_ack: begin
                o.wait_ack_pin = pin_level;
                e.wait_ack_pin = !drive;
            end
            pwr_ctrl_pkg::pin_sync_latch0: begin
                o.sync_latch_0_pin = pin_level;
                e.sync_latch_0_pin = !drive;
            end
            pwr_ctrl_pkg::pin_sync_latch1: begin
                o.sync_latch_1_pin = pin_level;
                e.sync_latch_1_pin = !drive;
            end
            default: begin
            end
        endcase
        wake_pin_out_o  = o;
        wake_pin_oe_n_o = e;
    end

    // ****************************************
    // ready flag
    // ****************************************
    // after any reset or core reset, wait for the config load to finish
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loading_q <= 1'b1;
        end else if (digital_reset_i || core_reset_i) begin
            loading_q <= 1'b1;
        end else if (config_loaded_i) begin
            loading_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_q      <= 1'b0;
            ready_prev_q <= 1'b0;
        end else begin
            ready_q      <= !loading_q && !sleep_trig_q && pll_locked_i
                            && !digital_reset_i && !core_reset_i;
            ready_prev_q <= ready_q;
        end
    end
    assign ready_o      = ready_q;
    assign ready_rise_o = ready_q && !ready_prev_q;

    // ****************************************
    // read path
    // ****************************************
    // readable in any state; host ignores data while not ready
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0;
            resp_q  <= 2'h0;
        end else if (avs_read && wait_q) begin
            resp_q  <= hit ? 2'h0 : 2'h3;
            rdata_q <= 32'h0;
            if (hit)
                rdata_q <= {sleep_sel_q, sleep_trig_q, auto_wake_q, led_off_q, 4'h0,
                            clk_gate_q, 3'h0, flag_b_q, flag_a_q, en_b_q, en_a_q, 4'h0,
                            pin_sel_q, buf_pp_q, 2'h0, pulse_mode_q, pol_high_q,
                            wake_en_q, ready_q};
        end else if (avs_write && wait_q) begin
            resp_q <= hit ? 2'h0 : 2'h3;
        end
    end
    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;

endmodule

// [pmwr_chk_sva.sv]
// checker: port-level assertions for the power control block
`timescale 1ns/1ns
module pmwr_chk (
    input wire logic                     clk_sys_i,
    input wire logic                     rst_n_i,
    input wire logic [11:0]              avs_address,
    input wire logic                     avs_read,
    input wire logic                     avs_write,
    input wire logic                     avs_waitrequest,
    input wire logic [1:0]               avs_response,
    input wire logic                     pll_locked_i,
    input wire logic                     sleep_active_o,
    input wire logic [2:0]               sleep_state_o,
    input wire logic                     ready_o,
    input wire logic                     ready_rise_o,
    input wire pwr_ctrl_pkg::wake_pins_s wake_pin_oe_n_o
);
    // every check lives in the system clock domain
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    property p_wait; (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("request not answered in one cycle");
    property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one: assert property (p_one) else $error("waitrequest low too long");
    property p_resp;
        (avs_read | avs_write) && avs_waitrequest |=> avs_response ==
            (($past(avs_address) == pwr_ctrl_pkg::power_control_status_off) ? 2'h0 : 2'h3);
    endproperty
    a_resp: assert property (p_resp) else $error("wrong response code");
    property p_rise; $rose(ready_o) |-> ready_rise_o; endproperty
    a_rise: assert property (p_rise) else $error("ready edge not signalled");
    property p_pulse; ready_rise_o |-> ready_o ##1 !ready_rise_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ready event not a single pulse");
    property p_sleep; sleep_active_o |=> !ready_o; endproperty
    a_sleep: assert property (p_sleep) else $error("ready high while sleeping");
    property p_pll; $rose(ready_o) |-> $past(pll_locked_i) && !sleep_active_o; endproperty
    a_pll: assert property (p_pll) else $error("ready rose without pll lock");
    property p_state; !sleep_active_o |-> sleep_state_o == pwr_ctrl_pkg::run_state; endproperty
    a_state: assert property (p_state) else $error("sleep state shown while awake");
    property p_pins; $onehot0(~wake_pin_oe_n_o); endproperty
    a_pins: assert property (p_pins) else $error("more than one wake pin driven");
endmodule

// [pmwr_host_model.sv]
// model: host board side of the wake output pins, with pull-ups
`timescale 1ns/1ns
module pmwr_host_model (
    input  wire pwr_ctrl_pkg::wake_pins_s pin_out_i,
    input  wire pwr_ctrl_pkg::wake_pins_s pin_oe_n_i,
    output pwr_ctrl_pkg::wake_pins_s      line_o
);
    // a released pin floats up to the pull-up, a driven one shows its value
    assign line_o = pin_oe_n_i | pin_out_i;
endmodule

// [power_mode_wake_ready_ctrl_tb_top.sv]
// testbench: register, sleep, wake, wake pin and reset scenarios
`timescale 1ns/1ns
module power_mode_wake_ready_ctrl_tb_top;
    logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [1:0]  avs_response, r;
    logic        digital_reset_i = 1'b0, core_reset_i = 1'b0, config_loaded_i = 1'b1;
    logic        pll_locked_i = 1'b1, host_wake_i = 1'b0, port_a_event_i = 1'b0;
    logic        port_b_event_i = 1'b0, avs_waitrequest, sleep_active_o, ready_o, ready_rise_o;
    logic        fieldbus_core_clock_gate_o, indicator_outputs_off_o, power_event_irq_status_o;
    logic [2:0]  sleep_state_o;
    pwr_ctrl_pkg::wake_pins_s wake_pin_out_o, wake_pin_oe_n_o, line;
    int          error_cnt = 0, total_checks = 0;
    localparam logic [11:0] pcs = pwr_ctrl_pkg::power_control_status_off;

    power_mode_wake_ready_ctrl #(.WAKE_PULSE_CYC(20)) dut (.clk_sys_i, .rst_n_i, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .avs_response, .digital_reset_i, .core_reset_i, .config_loaded_i, .pll_locked_i,
        .host_wake_i, .port_a_event_i, .port_b_event_i, .sleep_active_o, .sleep_state_o,
        .fieldbus_core_clock_gate_o, .indicator_outputs_off_o, .power_event_irq_status_o,
        .ready_o, .ready_rise_o, .wake_pin_out_o, .wake_pin_oe_n_o);
    pmwr_host_model host (.pin_out_i(wake_pin_out_o), .pin_oe_n_i(wake_pin_oe_n_o), .line_o(line));

    // 250 MHz system clock
    always #2 clk_sys_i = ~clk_sys_i;

    // compare, bus cycle and wait helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        @(posedge clk_sys_i iff avs_waitrequest === 1'b0);
        q = avs_readdata;
        r = avs_response;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h0);
        chk(q, e, m);
    endtask
    task automatic wait_ready;
        for (int n = 0; n < 200 && ready_o !== 1'b1; n++) @(posedge clk_sys_i);
        chk({31'h0, ready_o}, 32'h1, "ready");
    endtask

    // scenarios
    task automatic t_reset;
        wait_ready;
        rd(pcs, 32'h1, "reset value");
        rd(12'h088, 32'h0, "unmapped read");
        chk({30'h0, r}, 32'h3, "unmapped response");
    endtask
    task automatic t_gate;
        bus(1'b1, pcs, 32'h0420_0000);
        chk({31'h0, indicator_outputs_off_o}, 32'h1, "indicators off");
        bus(1'b1, pcs, 32'h0);
        bus(1'b1, pcs, 32'h0020_0000);
        chk({31'h0, fieldbus_core_clock_gate_o}, 32'h0, "gate after broken pair");
        bus(1'b1, pcs, 32'h0020_0000);
        rd(pcs, 32'h0020_0001, "gate after pair");
        bus(1'b1, pcs, 32'h0);
        chk({31'h0, fieldbus_core_clock_gate_o}, 32'h0, "gate cleared");
    endtask
    task automatic t_sleep;
        bus(1'b1, pcs, 32'h2000_0000);
        bus(1'b1, pcs, 32'h5000_0000);
        rd(pcs, 32'h2000_0001, "select change with trigger");
        bus(1'b1, pcs, 32'h3000_0000);
        chk({29'h0, sleep_state_o}, 32'h1, "sleep state out");
        rd(pcs, 32'h3000_0000, "sleeping");
        host_wake_i <= 1'b1;
        wait_ready;
        host_wake_i <= 1'b0;
        rd(pcs, 32'h1, "manual wake");
    endtask
    task automatic t_auto;
        bus(1'b1, pcs, 32'h2800_4000);
        bus(1'b1, pcs, 32'h3800_4000);
        port_a_event_i <= 1'b1;
        @(posedge clk_sys_i);
        wait_ready;
        rd(pcs, 32'h0801_4001, "auto wake");
        bus(1'b1, pcs, 32'h0001_4000);
        rd(pcs, 32'h0001_4001, "clear while source high");
        port_a_event_i <= 1'b0;
        bus(1'b1, pcs, 32'h0001_0000);
        rd(pcs, 32'h1, "flag cleared");
        port_b_event_i <= 1'b1;
        bus(1'b1, pcs, 32'h0000_8000);
        chk({31'h0, power_event_irq_status_o}, 32'h1, "port b event");
        port_b_event_i <= 1'b0;
        bus(1'b1, pcs, 32'h0);
        chk({31'h0, power_event_irq_status_o}, 32'h0, "port b off");
    endtask
    task automatic t_pin;
        bus(1'b1, pcs, 32'h0000_40c2);
        port_a_event_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        chk({31'h0, power_event_irq_status_o}, 32'h1, "irq status");
        chk({28'h0, wake_pin_oe_n_o}, 32'h7, "only error pin driven");
        chk({28'h0, line}, 32'h7, "push-pull active low");
        bus(1'b1, pcs, 32'h0000_40c6);
        chk({28'h0, line}, 32'hf, "push-pull active high");
        bus(1'b1, pcs, 32'h0000_4086);
        chk({28'h0, line}, 32'h7, "open drain ignores polarity");
        bus(1'b1, pcs, 32'h0000_4084);
        chk({28'h0, wake_pin_oe_n_o}, 32'hf, "pin released when disabled");
        chk({31'h0, power_event_irq_status_o}, 32'h1, "irq kept when disabled");
        bus(1'b1, pcs, 32'h0000_00ca);
        bus(1'b1, pcs, 32'h0000_40ca);
        repeat (5) @(posedge clk_sys_i);
        chk({28'h0, line}, 32'h7, "pulse active");
        repeat (20) @(posedge clk_sys_i);
        chk({28'h0, line}, 32'hf, "pulse ended");
        port_a_event_i <= 1'b0;
        bus(1'b1, pcs, 32'h0001_0084);
        chk({31'h0, power_event_irq_status_o}, 32'h0, "irq cleared");
    endtask
    task automatic t_dreset;
        @(posedge clk_sys_i);
        digital_reset_i <= 1'b1;
        @(posedge clk_sys_i);
        digital_reset_i <= 1'b0;
        @(posedge clk_sys_i);
        wait_ready;
        core_reset_i <= 1'b1;
        @(posedge clk_sys_i);
        core_reset_i <= 1'b0;
        @(posedge clk_sys_i);
        chk({31'h0, ready_o}, 32'h0, "core reset");
        wait_ready;
        rd(pcs, 32'h0000_0085, "kept across digital reset");
    endtask

    // verdict and end of run
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_gate;
        t_sleep;
        t_auto;
        t_pin;
        t_dreset;
        summarize;
    end

    // watchdog against a hung handshake
    initial begin
        #100000;
        error_cnt++;
        summarize;
    end
endmodule

bind power_mode_wake_ready_ctrl pmwr_chk chk_i (.clk_sys_i, .rst_n_i, .avs_address, .avs_read,
    .avs_write, .avs_waitrequest, .avs_response, .pll_locked_i, .sleep_active_o, .sleep_state_o,
    .ready_o, .ready_rise_o, .wake_pin_oe_n_o);
